// ### src/nvm_protect_cfg.svh
// Register offsets, field positions, command and error codes and the unlock window for the protection and status block.
`ifndef NVM_PROTECT_CFG_SVH
`define NVM_PROTECT_CFG_SVH
`define OFS_PROT_CTRL 8'h01
`define OFS_STATUS 8'h02
`define OFS_INT_ENABLE 8'h03
`define OFS_INT_FLAGS 8'h04
`define OFS_DATA_LO 8'h06
`define OFS_DATA_HI 8'h07
`define OFS_ADDR_LO 8'h08
`define OFS_ADDR_MID 8'h09
`define OFS_ADDR_EXT 8'h0A
`define BIT_CODE_LOCK 0
`define BIT_BOOT_LOCK 1
`define BIT_DATA_LOCK 2
`define BIT_FLASH_BUSY 0
`define BIT_EEPROM_BUSY 1
`define ERR_LSB 4
`define ERR_MSB 6
`define BIT_EEPROM_IDLE 0
`define CMD_NONE 7'h00
`define CMD_NOP 7'h01
`define ERR_NONE 3'h0
`define ERR_UNSUPPORTED 3'h1
`define ERR_PROTECTED 3'h2
`define ERR_OVERLAP 3'h3
`define UNLOCK_WINDOW 3'h4
`define NOP_OPCODE 16'h0000
`endif

// ### src/nvm_protect_pkg.sv
// Types shared by the protection and status block.
package nvm_protect_pkg;
    typedef enum logic [1:0] {
        SEC_BOOT = 2'b00,
        SEC_APP_CODE = 2'b01,
        SEC_APP_DATA = 2'b10,
        SEC_EEPROM = 2'b11
    } section_type;

    typedef struct packed {
        logic valid;
        logic is_write;
        section_type target;
    } nvm_op_type;

    typedef struct packed {
        logic valid;
        logic fetch;
        logic from_boot;
        logic [15:0] raw;
    } flash_rd_type;
endpackage

// ### src/nvm_protect_status_regs.sv
// Protection locks, status, ready interrupt and last data/address registers of the memory controller.
// Function
// - Data write lock blocks data writes until reset.
// - Code write lock blocks code writes until reset.
// - Protected boot data reads from elsewhere return zero.
// - Protected boot instruction fetches become no-operation.
// - Boot lock writable only from boot; reset clears.
// - Boot protection starts after leaving boot section.
// - Error field holds last error; zero write clears.
// - Error codes none, unsupported, protected, overlap.
// - EEPROM busy bit mirrors EEPROM operation.
// - Flash busy bit mirrors Flash operation.
// - Ready interrupt is enable AND flag level.
// - Ready flag clears only after EEPROM command issued; any command other than none or no-op counts here.
// - Ready flag set while idle; write one clears.
// - Data register captures last read value.
// - Data register as low and high bytes.
// - Address register holds last accessed address.
// - Address register as low, middle, extended bytes.
// - Programming command while busy records overlap error.
// - Lock register writes need unlock key within four instructions.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "nvm_protect_cfg.svh"
module nvm_protect_status_regs #(
    parameter int ADDR_BITS = 24
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // CPU context
    input wire logic exec_in_boot,
    input wire logic instr_retired,
    input wire logic change_protection_unlock,
    // Command path from the command register
    input wire logic cmd_written,
    input wire logic [6:0] cmd_code,
    input wire logic cmd_supported,
    // Memory operation requests and progress
    input wire nvm_protect_pkg::nvm_op_type op_req,
    output logic op_grant,
    input wire logic flash_op_active,
    input wire logic eeprom_op_active,
    // Flash read path
    input wire nvm_protect_pkg::flash_rd_type flash_rd,
    output logic [15:0] flash_rd_data,
    // Last access capture
    input wire logic access_done,
    input wire logic [15:0] access_data,
    input wire logic [ADDR_BITS-1:0] access_addr,
    // Lock states and interrupt
    output logic app_data_write_lock,
    output logic app_code_write_lock,
    output logic boot_read_lock,
    output logic eeprom_ready_irq
);
    import nvm_protect_pkg::*;

    // The lock bits are held apart from the armed boot protection, which lags the lock.
    logic data_lock_r, code_lock_r, boot_lock_r, boot_active_r;
    logic [2:0] err_r, err_nxt;
    logic [2:0] unlock_cnt_r;
    logic int_en_r, idle_flag_r;
    logic [15:0] data_r;
    logic [23:0] addr_r;
    logic [7:0] rdata_r;
    logic op_blocked, prot_wr, collision, eeprom_cmd;

    // Flags true for register writes to one address.
    function automatic logic wr_at(input logic [7:0] a);
        return reg_wr && reg_addr == a;
    endfunction

    // Counts the instructions left in which a protected write is accepted.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            unlock_cnt_r <= 3'h0;
        end else if (change_protection_unlock) begin
            unlock_cnt_r <= `UNLOCK_WINDOW;
        end else if (instr_retired && unlock_cnt_r != 3'h0) begin
            unlock_cnt_r <= unlock_cnt_r - 3'h1;
        end
    end

    assign prot_wr = wr_at(`OFS_PROT_CTRL) && unlock_cnt_r != 3'h0;

    // Locks are sticky; only reset clears them, so writing zero has no effect.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            data_lock_r <= 1'b0;
            code_lock_r <= 1'b0;
            boot_lock_r <= 1'b0;
        end else if (prot_wr) begin
            data_lock_r <= data_lock_r | reg_wdata[`BIT_DATA_LOCK];
            code_lock_r <= code_lock_r | reg_wdata[`BIT_CODE_LOCK];
            if (exec_in_boot) begin
                boot_lock_r <= boot_lock_r | reg_wdata[`BIT_BOOT_LOCK];
            end
        end
    end

    // Protection arms on the first cycle outside the boot section after the lock.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            boot_active_r <= 1'b0;
        end else begin
            if (boot_lock_r && !exec_in_boot) begin
                boot_active_r <= 1'b1;
            end
        end
    end

    // Filtering is combinational so that a protected word never reaches the CPU for even one cycle.
    // Boot code data reads of its own section are left unfiltered.
    always_comb begin
        flash_rd_data = flash_rd.raw;
        if (flash_rd.valid && boot_active_r) begin
            if (flash_rd.fetch) begin
                flash_rd_data = `NOP_OPCODE;
            end else if (!flash_rd.from_boot) begin
                flash_rd_data = 16'h0000;
            end
        end
    end

    // Only writes and erases are gated; the boot and EEPROM sections have no write lock here.
    always_comb begin
        op_blocked = 1'b0;
        if (op_req.valid && op_req.is_write) begin
            unique case (op_req.target)
                SEC_APP_DATA: op_blocked = data_lock_r;
                SEC_APP_CODE: op_blocked = code_lock_r;
                SEC_BOOT: op_blocked = 1'b0;
                SEC_EEPROM: op_blocked = 1'b0;
            endcase
        end
    end

    assign op_grant = op_req.valid && !op_blocked;
    assign collision = cmd_written && cmd_code != `CMD_NONE && cmd_code != `CMD_NOP
        && (flash_op_active || eeprom_op_active);

    // Hardware errors win over a software clear in the same cycle.
    always_comb begin
        err_nxt = err_r;
        if (wr_at(`OFS_STATUS) && reg_wdata[`ERR_MSB:`ERR_LSB] == 3'h0) begin
            err_nxt = `ERR_NONE;
        end
        if (cmd_written && !cmd_supported) begin
            err_nxt = `ERR_UNSUPPORTED;
        end
        if (op_blocked) begin
            err_nxt = `ERR_PROTECTED;
        end
        if (collision) begin
            err_nxt = `ERR_OVERLAP;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            err_r <= `ERR_NONE;
        end else begin
            err_r <= err_nxt;
        end
    end

    // Commands are not decoded by type, so any real command counts as an EEPROM start.
    // This is conservative: a Flash command also lets the ready flag be cleared.
    assign eeprom_cmd = cmd_written && cmd_code != `CMD_NONE && cmd_code != `CMD_NOP;

    // The enable is a plain read/write bit; software owns its timing around operations.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            int_en_r <= 1'b0;
        end else if (wr_at(`OFS_INT_ENABLE)) begin
            int_en_r <= reg_wdata[`BIT_EEPROM_IDLE];
        end
    end

    // Idle sets the flag continuously, so a clear only sticks once a command has been issued.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            idle_flag_r <= 1'b0;
        end else if (!eeprom_op_active && !eeprom_cmd) begin
            idle_flag_r <= 1'b1;
        end else if (wr_at(`OFS_INT_FLAGS) && reg_wdata[`BIT_EEPROM_IDLE]) begin
            idle_flag_r <= 1'b0;
        end
    end

    assign eeprom_ready_irq = int_en_r & idle_flag_r;

    // Hardware capture takes priority over a software write in the same cycle.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            data_r <= 16'h0000;
            addr_r <= 24'h000000;
        end else if (access_done) begin
            data_r <= access_data;
            addr_r <= 24'(access_addr);
        end else begin
            if (wr_at(`OFS_DATA_LO)) data_r[7:0] <= reg_wdata;
            if (wr_at(`OFS_DATA_HI)) data_r[15:8] <= reg_wdata;
            if (wr_at(`OFS_ADDR_LO)) addr_r[7:0] <= reg_wdata;
            if (wr_at(`OFS_ADDR_MID)) addr_r[15:8] <= reg_wdata;
            if (wr_at(`OFS_ADDR_EXT)) addr_r[23:16] <= reg_wdata;
        end
    end

    // Read data appear in the cycle after the strobe only; unmapped offsets read zero.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `OFS_PROT_CTRL: rdata_r <= {5'h00, data_lock_r, boot_lock_r, code_lock_r};
                `OFS_STATUS: rdata_r <= {1'b0, err_r, 2'b00, eeprom_op_active, flash_op_active};
                `OFS_INT_ENABLE: rdata_r <= {7'h00, int_en_r};
                `OFS_INT_FLAGS: rdata_r <= {7'h00, idle_flag_r};
                `OFS_DATA_LO: rdata_r <= data_r[7:0];
                `OFS_DATA_HI: rdata_r <= data_r[15:8];
                `OFS_ADDR_LO: rdata_r <= addr_r[7:0];
                `OFS_ADDR_MID: rdata_r <= addr_r[15:8];
                `OFS_ADDR_EXT: rdata_r <= addr_r[23:16];
                default: rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign reg_rdata = rdata_r;
    assign app_data_write_lock = data_lock_r;
    assign app_code_write_lock = code_lock_r;
    assign boot_read_lock = boot_active_r;

    sequence boot_locked_s;
        boot_lock_r && !exec_in_boot;
    endsequence

    locks_sticky_a: assert property (@(posedge mclk) disable iff (reset)
        $rose(data_lock_r) |=> data_lock_r [*8]) else $error("data lock dropped");
    code_sticky_a: assert property (@(posedge mclk) disable iff (reset)
        code_lock_r |=> code_lock_r) else $error("code lock dropped");
    boot_zero_a: assert property (@(posedge mclk) disable iff (reset)
        boot_active_r && flash_rd.valid && !flash_rd.fetch && !flash_rd.from_boot |-> flash_rd_data == 16'h0000)
        else $error("protected read leaked");
    boot_fetch_a: assert property (@(posedge mclk) disable iff (reset)
        boot_active_r && flash_rd.valid && flash_rd.fetch |-> flash_rd_data == `NOP_OPCODE)
        else $error("protected fetch leaked");
    boot_write_a: assert property (@(posedge mclk) disable iff (reset)
        $rose(boot_lock_r) |-> $past(exec_in_boot)) else $error("boot lock set outside boot");
    boot_arm_a: assert property (@(posedge mclk) disable iff (reset)
        boot_locked_s |=> boot_active_r) else $error("protection not armed");
    err_clear_a: assert property (@(posedge mclk) disable iff (reset)
        wr_at(`OFS_STATUS) && reg_wdata[6:4] == 3'h0 && !cmd_written && !op_blocked |=> err_r == 3'h0)
        else $error("error not cleared");
    err_overlap_a: assert property (@(posedge mclk) disable iff (reset)
        collision |=> err_r == `ERR_OVERLAP) else $error("overlap not recorded");
    irq_level_a: assert property (@(posedge mclk) disable iff (reset)
        eeprom_ready_irq == (int_en_r && idle_flag_r)) else $error("irq level wrong");
    flag_idle_a: assert property (@(posedge mclk) disable iff (reset)
        !eeprom_op_active && !eeprom_cmd |=> idle_flag_r) else $error("ready flag not set");
    prot_block_a: assert property (@(posedge mclk) disable iff (reset)
        op_req.valid && op_req.is_write && op_req.target == SEC_APP_DATA && data_lock_r
        |-> !op_grant ##1 err_r == `ERR_PROTECTED || err_r == `ERR_OVERLAP) else $error("locked write passed");
    unlock_gate_a: assert property (@(posedge mclk) disable iff (reset)
        wr_at(`OFS_PROT_CTRL) && unlock_cnt_r == 3'h0 |=> $stable(data_lock_r) && $stable(code_lock_r))
        else $error("lock written without key");
    capture_a: assert property (@(posedge mclk) disable iff (reset)
        access_done |=> data_r == $past(access_data)) else $error("data not captured");

    // Read-back checks: each byte must show the state sampled at its strobe.
    sequence status_read_s;
        reg_rd && reg_addr == `OFS_STATUS;
    endsequence

    sequence flags_read_s;
        reg_rd && reg_addr == `OFS_INT_FLAGS;
    endsequence

    sequence lock_read_s;
        reg_rd && reg_addr == `OFS_PROT_CTRL;
    endsequence

    // Busy bits come straight from the engine, so a stale value means a broken read path.
    status_busy_a: assert property (@(posedge mclk) disable iff (reset)
        status_read_s |=> reg_rdata[`BIT_EEPROM_BUSY] == $past(eeprom_op_active))
        else $error("eeprom busy wrong");
    flash_busy_a: assert property (@(posedge mclk) disable iff (reset)
        status_read_s |=> reg_rdata[`BIT_FLASH_BUSY] == $past(flash_op_active))
        else $error("flash busy wrong");
    status_err_a: assert property (@(posedge mclk) disable iff (reset)
        status_read_s |=> reg_rdata[`ERR_MSB:`ERR_LSB] == $past(err_r))
        else $error("error field wrong");
    flag_read_a: assert property (@(posedge mclk) disable iff (reset)
        flags_read_s |=> reg_rdata[`BIT_EEPROM_IDLE] == $past(idle_flag_r))
        else $error("ready flag read wrong");
    lock_data_read_a: assert property (@(posedge mclk) disable iff (reset)
        lock_read_s |=> reg_rdata[`BIT_DATA_LOCK] == $past(data_lock_r))
        else $error("data lock read wrong");
    lock_code_read_a: assert property (@(posedge mclk) disable iff (reset)
        lock_read_s |=> reg_rdata[`BIT_CODE_LOCK] == $past(code_lock_r))
        else $error("code lock read wrong");
    lock_boot_read_a: assert property (@(posedge mclk) disable iff (reset)
        lock_read_s |=> reg_rdata[`BIT_BOOT_LOCK] == $past(boot_lock_r))
        else $error("boot lock read wrong");
    rdata_idle_a: assert property (@(posedge mclk) disable iff (reset)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside slot");

    // Lock bits and the armed protection may only be cleared by reset, and protection never arms inside boot.
    data_sticky_a: assert property (@(posedge mclk) disable iff (reset)
        data_lock_r |=> data_lock_r)
        else $error("data lock cleared");
    boot_sticky_a: assert property (@(posedge mclk) disable iff (reset)
        boot_lock_r |=> boot_lock_r)
        else $error("boot lock cleared");
    armed_sticky_a: assert property (@(posedge mclk) disable iff (reset)
        boot_active_r |=> boot_active_r)
        else $error("boot protection dropped");
    arm_wait_a: assert property (@(posedge mclk) disable iff (reset)
        !boot_active_r && exec_in_boot |=> !boot_active_r)
        else $error("protection armed inside boot");

    // Gating and error recording for operations and commands.
    code_block_a: assert property (@(posedge mclk) disable iff (reset)
        op_req.valid && op_req.is_write && op_req.target == SEC_APP_CODE && code_lock_r |-> !op_grant)
        else $error("locked code write passed");
    eeprom_grant_a: assert property (@(posedge mclk) disable iff (reset)
        op_req.valid && op_req.target == SEC_EEPROM |-> op_grant)
        else $error("eeprom operation refused");
    err_unsup_a: assert property (@(posedge mclk) disable iff (reset)
        cmd_written && !cmd_supported && !collision && !op_blocked |=> err_r == `ERR_UNSUPPORTED)
        else $error("unsupported command not recorded");
    err_hold_a: assert property (@(posedge mclk) disable iff (reset)
        !wr_at(`OFS_STATUS) && !cmd_written && !op_blocked |=> $stable(err_r))
        else $error("error field changed alone");

    // The ready flag clears only by software, and only once a command has started.
    flag_clear_a: assert property (@(posedge mclk) disable iff (reset)
        wr_at(`OFS_INT_FLAGS) && reg_wdata[`BIT_EEPROM_IDLE] && (eeprom_op_active || eeprom_cmd) |=> !idle_flag_r)
        else $error("ready flag not cleared");
    flag_keep_a: assert property (@(posedge mclk) disable iff (reset)
        idle_flag_r && !wr_at(`OFS_INT_FLAGS) |=> idle_flag_r)
        else $error("ready flag dropped");

    // Capture, byte access and the unlock window.
    addr_capture_a: assert property (@(posedge mclk) disable iff (reset)
        access_done |=> addr_r[ADDR_BITS-1:0] == $past(access_addr))
        else $error("address not captured");
    byte_write_a: assert property (@(posedge mclk) disable iff (reset)
        wr_at(`OFS_DATA_HI) && !access_done |=> data_r[15:8] == $past(reg_wdata))
        else $error("high data byte not written");
    window_load_a: assert property (@(posedge mclk) disable iff (reset)
        change_protection_unlock |=> unlock_cnt_r == `UNLOCK_WINDOW)
        else $error("unlock window not opened");
endmodule
`default_nettype wire

// ### test/nvm_protect_status_regs_tb.sv
// Self-checking testbench for the protection, status and last-access registers.
`timescale 1ns/100ps
`default_nettype none
module nvm_protect_status_regs_tb;
    import nvm_protect_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, exec_in_boot, instr_retired, change_protection_unlock;
    logic cmd_written, cmd_supported, flash_op_active, eeprom_op_active, access_done, op_grant;
    logic app_data_write_lock, app_code_write_lock, boot_read_lock, eeprom_ready_irq;
    logic [6:0] cmd_code;
    nvm_op_type op_req;
    flash_rd_type flash_rd;
    logic [15:0] flash_rd_data, access_data;
    logic [23:0] access_addr;
    int err_total = 0;
    int samples_checked = 0;
    logic [7:0] cap_bytes [5] = '{8'h5A, 8'hA5, 8'h56, 8'h34, 8'h12};

    nvm_protect_status_regs i_dut (.mclk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .exec_in_boot, .instr_retired, .change_protection_unlock, .cmd_written, .cmd_code, .cmd_supported,
        .op_req, .op_grant, .flash_op_active, .eeprom_op_active, .flash_rd, .flash_rd_data, .access_done,
        .access_data, .access_addr, .app_data_write_lock, .app_code_write_lock, .boot_read_lock,
        .eeprom_ready_irq);

    always #5 mclk = ~mclk;

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe, so it is sampled just past that edge.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask

    task automatic op(input section_type t, input logic exp_grant);
        @(posedge mclk);
        op_req <= '{valid: 1'b1, is_write: 1'b1, target: t};
        #1 chk(op_grant, exp_grant);
        @(posedge mclk);
        op_req <= '0;
    endtask

    task automatic cmd(input logic [6:0] c, input logic sup);
        @(posedge mclk);
        cmd_written <= 1'b1;
        cmd_code <= c;
        cmd_supported <= sup;
        @(posedge mclk);
        cmd_written <= 1'b0;
    endtask

    task automatic unlock();
        @(posedge mclk);
        change_protection_unlock <= 1'b1;
        @(posedge mclk);
        change_protection_unlock <= 1'b0;
    endtask

    task automatic fr(input logic f, input logic fb, input logic [15:0] raw, input logic [15:0] exp);
        @(posedge mclk);
        flash_rd <= '{valid: 1'b1, fetch: f, from_boot: fb, raw: raw};
        #1 chk(flash_rd_data, exp);
        @(posedge mclk);
        flash_rd <= '0;
    endtask

    task automatic wrap_up();
        $display("checks=%0d errors=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // The whole sequence needs well under a thousand cycles.
    initial begin
        #20000;
        err_total++;
        wrap_up();
    end

    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, exec_in_boot, instr_retired} = '0;
        {change_protection_unlock, cmd_written, cmd_code, cmd_supported} = '0;
        {flash_op_active, eeprom_op_active, access_done, access_data, access_addr} = '0;
        op_req = '0;
        flash_rd = '0;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        rd(8'h02, 8'h00);
        rd(8'h03, 8'h00);
        rd(8'h04, 8'h01);
        rd(8'h05, 8'h00);
        wr(8'h01, 8'h07);
        rd(8'h01, 8'h00);
        unlock();
        op(SEC_APP_DATA, 1'b1);
        wr(8'h01, 8'h07);
        rd(8'h01, 8'h05);
        chk({app_data_write_lock, boot_read_lock, app_code_write_lock}, 24'h5);
        unlock();
        wr(8'h01, 8'h00);
        rd(8'h01, 8'h05);
        op(SEC_APP_DATA, 1'b0);
        rd(8'h02, 8'h20);
        op(SEC_APP_CODE, 1'b0);
        op(SEC_EEPROM, 1'b1);
        wr(8'h02, 8'h00);
        rd(8'h02, 8'h00);
        cmd(7'h05, 1'b0);
        rd(8'h02, 8'h10);
        wr(8'h02, 8'h70);
        rd(8'h02, 8'h10);
        flash_op_active <= 1'b1;
        wr(8'h02, 8'h00);
        cmd(7'h01, 1'b1);
        rd(8'h02, 8'h01);
        cmd(7'h12, 1'b1);
        rd(8'h02, 8'h31);
        wr(8'h02, 8'h03);
        rd(8'h02, 8'h01);
        flash_op_active <= 1'b0;
        eeprom_op_active <= 1'b1;
        rd(8'h02, 8'h02);
        wr(8'h03, 8'h01);
        #1 chk(eeprom_ready_irq, 1'b1);
        wr(8'h04, 8'h01);
        rd(8'h04, 8'h00);
        chk(eeprom_ready_irq, 1'b0);
        eeprom_op_active <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk(eeprom_ready_irq, 1'b1);
        wr(8'h04, 8'h01);
        rd(8'h04, 8'h01);
        wr(8'h03, 8'h00);
        #1 chk(eeprom_ready_irq, 1'b0);
        @(posedge mclk);
        access_done <= 1'b1;
        access_data <= 16'hA55A;
        access_addr <= 24'h123456;
        @(posedge mclk);
        access_done <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            rd(8'h06 + 8'(i), cap_bytes[i]);
        end
        wr(8'h07, 8'h3C);
        rd(8'h07, 8'h3C);
        unlock();
        @(posedge mclk);
        instr_retired <= 1'b1;
        exec_in_boot <= 1'b1;
        repeat (4) @(posedge mclk);
        instr_retired <= 1'b0;
        wr(8'h01, 8'h02);
        rd(8'h01, 8'h05);
        unlock();
        wr(8'h01, 8'h02);
        rd(8'h01, 8'h07);
        chk(boot_read_lock, 1'b0);
        fr(1'b1, 1'b1, 16'hBEEF, 16'hBEEF);
        exec_in_boot <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk(boot_read_lock, 1'b1);
        fr(1'b1, 1'b1, 16'hBEEF, 16'h0000);
        fr(1'b0, 1'b0, 16'h1234, 16'h0000);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        rd(8'h01, 8'h00);
        chk(boot_read_lock, 1'b0);
        wrap_up();
    end
endmodule
`default_nettype wire
